// >>> include/enc_cc_pkg.sv
// Constants for the encoder capture/compare control block.
// Assumes an APB master on pclk (100 MHz) and asynchronous pins per channel.
// Notes on behaviour
// R1 - Select 0: channel compares against own counter, output on own compare line only.
// R2 - Select 1: compare against group's first counter, also ORed into first output.
// R3 - First channel of each group keeps select at 1; writes of 0 ignored.
// R4 - Triggers 0,4,8,12 software; 1,9 index rising; 5,13 index falling.
// R5 - Triggers 2,6 flag rising; 10,14 flag falling.
// R6 - Triggers 3,7,11,15 use AND of index and flag with listed inversions.
// R7 - Capture uses only the index and flags of the captured channel.
// R8 - Trigger select changing from 0/8 to 4/12 captures immediately.
// R9 - Reading the capture register arms; capture fires on input levels.
// R10 - Two-bit flag select picks home, limit or user flag for capture.
// R11 - Gated index off: raw index feeds the capture logic.
// R12 - Gated index on: index gated by quadrature state, one state wide.
// R13 - Gated on with trigger bit 0 clear: capture on first hall edge.
// R14 - Status bits 0..2 report which hall edge caused the capture.
// R15 - Gate state 0 passes index at A,B high; 1 at A,B low.
// R16 - Output format 0..3 sets A/B PWM or DAC and C PWM or pulse-frequency.
// R17 - Reset defaults: select 0 (1 on each group's first channel), trigger 1, flag 0, gate 0, state 0, format 0.
// R18 - Compare output high while selected counter equals compare register.
package enc_cc_pkg;
  localparam int n_chan = 8;
  localparam int group_size = 4;
  localparam int cnt_w = 24;
  // Per-channel register block: 16 bytes per channel
  localparam logic [7:0] chan_stride = 8'h10;
  localparam logic [3:0] off_ctrl = 4'h0;
  localparam logic [3:0] off_cmp = 4'h4;
  localparam logic [3:0] off_cap = 4'h8;
  localparam logic [3:0] off_stat = 4'hc;
  localparam logic [7:0] off_int_stat = 8'h80;
  localparam logic [7:0] off_int_mask = 8'h84;
  // Control word fields
  localparam int f_cmp_sel = 0;
  localparam int f_trig = 4;
  localparam int f_flag = 8;
  localparam int f_gate_en = 12;
  localparam int f_gate_state = 13;
  localparam int f_fmt = 16;
  // Defaults
  localparam logic [3:0] rst_trig = 4'h1;
  localparam logic [1:0] rst_flag = 2'h0;
  localparam logic [1:0] rst_fmt = 2'h0;
  // Status bits
  localparam int f_armed = 3;
  localparam int f_capt = 4;
endpackage

// >>> logic/enc_capture_compare.sv
// Eight-channel encoder capture and compare control with APB registers.
// Assumes counters are supplied from outside; pins are asynchronous.
module enc_capture_compare
  import enc_cc_pkg::*;
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Encoder counters, same clock
  input wire logic [n_chan*cnt_w-1:0] enc_count,
  // Pins per channel
  input wire logic [n_chan-1:0] quad_a_in,
  input wire logic [n_chan-1:0] quad_b_in,
  input wire logic [n_chan-1:0] index_in_n,
  input wire logic [n_chan-1:0] home_flag_in,
  input wire logic [n_chan-1:0] plim_flag_in,
  input wire logic [n_chan-1:0] mlim_flag_in,
  input wire logic [n_chan-1:0] user_flag_in,
  // Outputs
  output logic [n_chan-1:0] compare_out_n,
  output logic [n_chan-1:0] ab_dac_mode,
  output logic [n_chan-1:0] pulse_freq_output,
  output logic irq
);
  localparam int n_pins = 7;

  // Three-stage synchronisers; first stage feeds only the second
  logic [n_pins*n_chan-1:0] s1, s2, s3, pin_state;
  wire [n_pins*n_chan-1:0] raw_pins = {quad_a_in, quad_b_in, index_in_n, home_flag_in,
    plim_flag_in, mlim_flag_in, user_flag_in};
  wire [n_pins*n_chan-1:0] agree = ~(s2 ^ s3);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      pin_state <= '0;
    end else begin
      s1 <= raw_pins;
      s2 <= s1;
      s3 <= s2;
      pin_state <= (agree & s3) | (~agree & pin_state);
    end
  end

  wire [n_chan-1:0] qa = pin_state[7*n_chan-1:6*n_chan];
  wire [n_chan-1:0] qb = pin_state[6*n_chan-1:5*n_chan];
  wire [n_chan-1:0] idx = pin_state[5*n_chan-1:4*n_chan];
  wire [n_chan-1:0] fl_home = pin_state[4*n_chan-1:3*n_chan];
  wire [n_chan-1:0] fl_plim = pin_state[3*n_chan-1:2*n_chan];
  wire [n_chan-1:0] fl_mlim = pin_state[2*n_chan-1:n_chan];
  wire [n_chan-1:0] fl_user = pin_state[n_chan-1:0];

  // APB decode: one-cycle access, zero wait
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire chan_hit = (paddr[7] == 1'b0);
  wire [2:0] ch_sel = paddr[6:4];
  wire [3:0] reg_off = paddr[3:0];
  wire int_stat_hit = (paddr == off_int_stat);
  wire int_mask_hit = (paddr == off_int_mask);
  wire mapped = (chan_hit & (reg_off[1:0] == 2'b00)) | int_stat_hit | int_mask_hit;
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;

  // Per-channel state
  logic [n_chan-1:0] cmp_sel, gate_en, gate_state, armed, capt_done;
  logic [3:0] trig [n_chan];
  logic [1:0] flag_sel [n_chan];
  logic [1:0] fmt [n_chan];
  logic [cnt_w-1:0] cmp_val [n_chan];
  logic [cnt_w-1:0] cap_val [n_chan];
  logic [2:0] hall_cause [n_chan];
  logic [n_chan-1:0] idx_d, flag_d;
  logic [2:0] hall_d [n_chan];
  logic [n_chan-1:0] int_stat, int_mask;
  logic [n_chan-1:0] cap_event;
  logic [n_chan-1:0] hit;
  logic [31:0] ctrl_word [n_chan];
  logic [31:0] stat_word [n_chan];

  function automatic logic edge_or_level(input logic cur, input logic prev,
                                         input logic rising, input logic level);
    edge_or_level = level ? (rising ? cur : ~cur)
                          : (rising ? (cur & ~prev) : (~cur & prev));
  endfunction

  genvar g;
  generate
    for (g = 0; g < n_chan; g++) begin : ch
      localparam int first = (g / group_size) * group_size;
      wire [cnt_w-1:0] own_cnt = enc_count[g*cnt_w +: cnt_w];
      wire [cnt_w-1:0] grp_cnt = enc_count[first*cnt_w +: cnt_w];
      // Constant, so the reset branch below loads a constant
      localparam logic is_first = (g == first);
      wire sel_reg = wr & chan_hit & (ch_sel == 3'(g));
      wire ctrl_wr = sel_reg & (reg_off == off_ctrl);
      wire cmp_wr = sel_reg & (reg_off == off_cmp);
      wire cap_rd = rd & chan_hit & (ch_sel == 3'(g)) & (reg_off == off_cap);
      // Compare counter choice
      wire [cnt_w-1:0] cmp_cnt = cmp_sel[g] ? grp_cnt : own_cnt; // [R1] [R2]
      assign hit[g] = (cmp_cnt == cmp_val[g]); // [R18]
      // Flag and index sources of this channel only [R7]
      wire [3:0] flags = {fl_user[g], fl_mlim[g], fl_plim[g], fl_home[g]};
      wire flag_v = flags[flag_sel[g]]; // [R10]
      wire gate_ok = gate_state[g] ? (~qa[g] & ~qb[g]) : (qa[g] & qb[g]); // [R15]
      wire gated_index_signal = idx[g] & gate_ok; // [R12]
      wire idx_v = gate_en[g] ? gated_index_signal : idx[g]; // [R11]
      wire [3:0] t = trig[g];
      wire [2:0] hall = {qa[g], qb[g], idx[g]};
      wire [2:0] hall_chg = hall ^ hall_d[g];
      wire hall_mode = gate_en[g] & ~t[0]; // [R13]
      // Level evaluation while armed: the first cycle after arming sees the level
      wire lvl = armed[g];
      wire idx_trig = edge_or_level(idx_v, idx_d[g], ~t[2], lvl); // [R4]
      wire flag_trig = edge_or_level(flag_v, flag_d[g], ~t[3], lvl); // [R5]
      wire and_trig = (idx_v ^ t[2]) & (flag_v ^ t[3]); // [R6]
      wire [3:0] new_t = pwdata[f_trig +: 4];
      wire sw_trig = ctrl_wr & ((t == 4'h0) | (t == 4'h8))
                     & ((new_t == 4'h4) | (new_t == 4'hc)); // [R8]
      logic hw_trig;
      always_comb begin
        if (hall_mode) hw_trig = |hall_chg;
        else begin
          unique case (t[1:0])
            2'b00: hw_trig = 1'b0;
            2'b01: hw_trig = idx_trig;
            2'b10: hw_trig = flag_trig;
            2'b11: hw_trig = and_trig;
          endcase
        end
      end
      assign cap_event[g] = sw_trig | (armed[g] & hw_trig);

      // Previous values for the edge and hall-change detectors
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          idx_d[g] <= 1'b0;
          flag_d[g] <= 1'b0;
          hall_d[g] <= 3'h0;
        end else begin
          idx_d[g] <= idx_v;
          flag_d[g] <= flag_v;
          hall_d[g] <= hall;
        end
      end

      // Whole-word write: every field but a first channel's select is replaced at once
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cmp_sel[g] <= is_first; // [R3] [R17]
          trig[g] <= rst_trig;
          flag_sel[g] <= rst_flag;
          gate_en[g] <= 1'b0;
          gate_state[g] <= 1'b0;
          fmt[g] <= rst_fmt;
        end else if (ctrl_wr) begin
          cmp_sel[g] <= is_first | pwdata[f_cmp_sel]; // [R3]
          trig[g] <= new_t;
          flag_sel[g] <= pwdata[f_flag +: 2];
          gate_en[g] <= pwdata[f_gate_en];
          gate_state[g] <= pwdata[f_gate_state];
          fmt[g] <= pwdata[f_fmt +: 2];
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) cmp_val[g] <= '0;
        else if (cmp_wr) cmp_val[g] <= pwdata[cnt_w-1:0];
      end

      // Capture beats a read in the same cycle, so no event is lost to re-arming
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cap_val[g] <= '0;
          armed[g] <= 1'b0;
          capt_done[g] <= 1'b0;
        end else if (cap_event[g]) begin
          cap_val[g] <= own_cnt;
          armed[g] <= 1'b0;
          capt_done[g] <= 1'b1;
        end else if (cap_rd) begin
          armed[g] <= 1'b1; // [R9]
          capt_done[g] <= 1'b0;
        end
      end

      // Cause kept until the next hall-edge capture
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) hall_cause[g] <= 3'h0;
        else if (cap_event[g] & hall_mode & ~sw_trig) hall_cause[g] <= hall_chg; // [R14]
      end

      // Register images for the read mux
      assign ctrl_word[g] = {14'h0, fmt[g], 2'h0, gate_state[g], gate_en[g],
                             2'h0, flag_sel[g], t, 3'h0, cmp_sel[g]};
      assign stat_word[g] = {27'h0, capt_done[g], armed[g], hall_cause[g]};

      // Own hit, plus hits of followers with select 1 when this is the group's first channel
      logic grp_or;
      always_comb begin
        grp_or = 1'b0;
        for (int k = 1; k < group_size; k++) begin
          if (is_first & cmp_sel[(g + k) % n_chan]) grp_or = grp_or | hit[(g + k) % n_chan];
        end
      end
      assign compare_out_n[g] = hit[g] | grp_or; // [R2]
      assign ab_dac_mode[g] = fmt[g][0]; // [R16]
      assign pulse_freq_output[g] = fmt[g][1]; // [R16]
    end
  endgenerate

  // Interrupt status: capture events, write one to clear
  wire int_clr_wr = wr & int_stat_hit;
  wire [n_chan-1:0] int_clr = int_clr_wr ? pwdata[n_chan-1:0] : '0;
  // A new event beats a clear in the same cycle, so none is lost
  wire [n_chan-1:0] next_int_stat = (int_stat & ~int_clr) | cap_event;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) int_stat <= '0;
    else int_stat <= next_int_stat;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) int_mask <= '0;
    else if (wr & int_mask_hit) int_mask <= pwdata[n_chan-1:0];
  end
  assign irq = |(int_stat & int_mask);

  // Read mux
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0;
    if (int_stat_hit) rd_word = {24'h0, int_stat};
    else if (int_mask_hit) rd_word = {24'h0, int_mask};
    else if (chan_hit) begin
      unique case (reg_off)
        off_ctrl: rd_word = ctrl_word[ch_sel];
        off_cmp: rd_word = {8'h0, cmp_val[ch_sel]};
        off_cap: rd_word = {8'h0, cap_val[ch_sel]};
        off_stat: rd_word = stat_word[ch_sel];
        default: rd_word = 32'h0;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0;
    else if (psel & ~penable & ~pwrite) prdata <= rd_word;
  end
endmodule

// >>> verification/enc_cc_sva.sv
// Checker for the capture/compare block's bus and level outputs.
// Assumes a bind to the top module; single pclk domain.
module enc_cc_sva
  import enc_cc_pkg::*;
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Outputs
  input wire logic [n_chan-1:0] ab_dac_mode,
  input wire logic [n_chan-1:0] pulse_freq_output,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s; psel && !penable; endsequence
  sequence access_s; psel && penable; endsequence
  pready_acc_a: assert property (setup_s ##1 access_s |-> pready)
    else $error("pready low in access phase");
  slverr_map_a: assert property (psel && penable && paddr >= 8'h88 |-> pslverr)
    else $error("unmapped access without pslverr");
  slverr_ok_a: assert property (psel && penable && paddr < 8'h80 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("pslverr on channel register");
  slverr_idle_a: assert property (!(psel && penable) |-> !pslverr)
    else $error("pslverr outside access phase");
  // Read data only moves after a read setup
  rd_hold_a: assert property (!($past(psel) && !$past(penable) && !$past(pwrite)) |-> $stable(prdata))
    else $error("prdata moved without read");
  dac_wr_a: assert property ($changed(ab_dac_mode) |-> $past(psel && penable && pwrite))
    else $error("dac mode moved without write");
  pfm_wr_a: assert property ($changed(pulse_freq_output) |-> $past(psel && penable && pwrite))
    else $error("pulse mode moved without write");
  irq_fall_a: assert property ($fell(irq) |-> $past(psel && penable && pwrite))
    else $error("irq fell without write");
endmodule

// >>> verification/enc_pins_model.sv
// Encoder index and flag pins as the far side presents them.
// Assumes the bench commands levels; quadrature stays parked low-low.
module enc_pins_model
  import enc_cc_pkg::*;
(
  // Commands
  input wire logic [n_chan-1:0] drive_index,
  input wire logic [n_chan-1:0] drive_home,
  input wire logic [n_chan-1:0] drive_user,
  input wire logic [n_chan-1:0] drive_plim,
  input wire logic [n_chan-1:0] drive_mlim,
  // Pins
  output logic [n_chan-1:0] quad_a_in,
  output logic [n_chan-1:0] quad_b_in,
  output logic [n_chan-1:0] index_in_n,
  output logic [n_chan-1:0] home_flag_in,
  output logic [n_chan-1:0] plim_flag_in,
  output logic [n_chan-1:0] mlim_flag_in,
  output logic [n_chan-1:0] user_flag_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // Parked quadrature keeps the A and B bits of hall decode quiet
  assign quad_a_in = '0;
  assign quad_b_in = '0;
  assign index_in_n = drive_index;
  assign home_flag_in = drive_home;
  assign user_flag_in = drive_user;
  assign plim_flag_in = drive_plim;
  assign mlim_flag_in = drive_mlim;
endmodule

// >>> verification/testbench.sv
// Bench for the capture/compare block: APB master, pins model, checker bind.
// Assumes zero-wait APB slave and level pins synchronised inside the block.
module testbench import enc_cc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic [n_chan*cnt_w-1:0] enc_count = '0;
  logic [n_chan-1:0] quad_a_in, quad_b_in, index_in_n, home_flag_in, user_flag_in;
  logic [n_chan-1:0] plim_flag_in, mlim_flag_in;
  logic [n_chan-1:0] drv_plim = '0, drv_mlim = '0;
  logic [n_chan-1:0] compare_out_n, ab_dac_mode, pulse_freq_output;
  logic [n_chan-1:0] drv_idx = '0, drv_home = '0, drv_user = '0;
  int fails = 0, tests_run = 0;
  enc_capture_compare enc_capture_compare_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .enc_count, .quad_a_in, .quad_b_in,
    .index_in_n, .home_flag_in, .plim_flag_in, .mlim_flag_in, .user_flag_in,
    .compare_out_n, .ab_dac_mode, .pulse_freq_output, .irq);
  enc_pins_model enc_pins_model_inst (.drive_index(drv_idx), .drive_home(drv_home),
    .drive_user(drv_user), .drive_plim(drv_plim), .drive_mlim(drv_mlim), .quad_a_in,
    .quad_b_in, .index_in_n, .home_flag_in, .plim_flag_in, .mlim_flag_in, .user_flag_in);
  always #5 pclk = ~pclk;
  task print_verdict;
    if (fails == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic logic [7:0] ra(input int ch, input logic [3:0] off);
    return chan_stride * 8'(ch) + {4'h0, off};
  endfunction
  // Ends one edge past the access edge so register outputs have landed
  task apb(input int w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= (w != 0);
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    if (a == 8'h88) chk("slverr", 32'(pslverr), 32'h1);
    if (pready !== 1'b1) begin
      fails++;
      print_verdict();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task reset_defaults;
    apb(0, ra(1, off_ctrl), 0);
    chk("ctrl1", q, 32'h10);
    apb(0, ra(0, off_ctrl), 0);
    chk("ctrl0", q, 32'h11);
    chk("fmt", 32'({ab_dac_mode, pulse_freq_output}), 32'h0);
  endtask
  task formats;
    for (int f = 0; f < 4; f++) begin
      apb(1, ra(2, off_ctrl), 32'(f) << f_fmt);
      chk("dac", 32'(ab_dac_mode[2]), 32'(f % 2));
      chk("pfm", 32'(pulse_freq_output[2]), 32'(f / 2));
    end
  endtask
  task compare_sel;
    enc_count[cnt_w-1:0] <= 24'h9;
    enc_count[cnt_w +: cnt_w] <= 24'h5;
    apb(1, ra(0, off_cmp), 32'h7);
    apb(1, ra(1, off_cmp), 32'h5);
    chk("eq_own", 32'(compare_out_n[1:0]), 32'h2);
    apb(1, ra(1, off_ctrl), 32'h1);
    chk("eq_grp", 32'(compare_out_n[1:0]), 32'h0);
    apb(1, ra(1, off_cmp), 32'h9);
    chk("eq_or", 32'(compare_out_n[1:0]), 32'h3);
    apb(1, ra(0, off_ctrl), 32'h10);
    apb(0, ra(0, off_ctrl), 0);
    chk("sel0", q, 32'h11);
  endtask
  task sw_cap;
    enc_count[3*cnt_w +: cnt_w] <= 24'h123456;
    apb(1, ra(3, off_ctrl), 32'h0);
    apb(1, ra(3, off_ctrl), 32'h40);
    apb(0, off_int_stat, 0);
    chk("ist", q, 32'h8);
    chk("irq", 32'(irq), 32'h1);
    apb(1, off_int_mask, 32'h0);
    chk("irq_m", 32'(irq), 32'h0);
    apb(1, off_int_stat, 32'h8);
    apb(1, off_int_mask, 32'hff);
    chk("irq_c", 32'(irq), 32'h0);
    apb(0, ra(3, off_cap), 0);
    chk("cap3", q, 32'h123456);
    apb(0, 8'h88, 0);
    chk("unmap", q, 32'h0);
  endtask
  // Foreign pins go high first; only the own selected pin may fire
  task cap_case(input int ch, input logic [31:0] ctrl, input logic [4:0] good);
    int n;
    enc_count[ch*cnt_w +: cnt_w] <= 24'(ch * 24'h10101);
    apb(1, ra(ch, off_ctrl), ctrl);
    apb(0, ra(ch, off_cap), 0);
    drv_idx <= ~(8'(good[0]) << ch);
    drv_home <= ~(8'(good[1]) << ch);
    drv_user <= ~(8'(good[2]) << ch);
    drv_plim <= ~(8'(good[3]) << ch);
    drv_mlim <= ~(8'(good[4]) << ch);
    repeat (10) @(posedge pclk);
    apb(0, off_int_stat, 0);
    chk("idle", 32'(q[ch]), 32'h0);
    drv_idx <= '1;
    drv_home <= '1;
    drv_user <= '1;
    drv_plim <= '1;
    drv_mlim <= '1;
    n = 0;
    do begin
      apb(0, off_int_stat, 0);
      n++;
    end while (q[ch] !== 1'b1 && n < 20);
    chk("hit", 32'(q[ch]), 32'h1);
    if (q[ch] !== 1'b1) print_verdict();
    apb(0, ra(ch, off_cap), 0);
    chk("cap", q, 32'(ch * 24'h10101));
    drv_idx <= '0;
    drv_home <= '0;
    drv_user <= '0;
    drv_plim <= '0;
    drv_mlim <= '0;
    repeat (8) @(posedge pclk);
    apb(1, off_int_stat, 32'hff);
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    reset_defaults();
    formats();
    compare_sel();
    apb(1, off_int_mask, 32'hff);
    sw_cap();
    cap_case(2, 32'h10, 5'b00001);
    cap_case(5, 32'h320, 5'b00100);
    cap_case(6, 32'h20, 5'b00010);
    cap_case(7, 32'h160, 5'b01000);
    cap_case(1, 32'h260, 5'b10000);
    cap_case(4, 32'h30, 5'b00011);
    cap_case(3, 32'h3010, 5'b00001);
    print_verdict();
  end
endmodule
bind enc_capture_compare enc_cc_sva enc_cc_sva_inst (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .ab_dac_mode, .pulse_freq_output, .irq);
